// ---- hw/gps_pkg.sv ----
/*
 * Shared constants and types of the general-purpose pin port block:
 * register offsets, field positions, reset values, sense modes, override bundle.
 * Assumes a Wishbone classic slave with 32-bit data and byte addresses.
 */
package gps_pkg;

	// Pins per port
	localparam int PINS = 8;

	// Register byte offsets
	localparam logic [7:0] OFS_DIR = 8'h00;
	localparam logic [7:0] OFS_OUT = 8'h04;
	localparam logic [7:0] OFS_SAMPLE = 8'h08;
	localparam logic [7:0] OFS_MCU = 8'h0c;
	localparam logic [7:0] OFS_INTEN = 8'h10;
	localparam logic [7:0] OFS_FLAG = 8'h14;

	// Control register fields
	localparam int MCU_PUD_BIT = 6;
	localparam int MCU_SENSE_LO = 0;
	localparam logic [7:0] MCU_WR_MASK = 8'h43;

	// Reset values
	localparam logic [PINS-1:0] DIR_RST = 8'h00;
	localparam logic [PINS-1:0] OUT_RST = 8'h00;
	localparam logic [7:0] MCU_RST = 8'h00;
	localparam logic [PINS-1:0] INTEN_RST = 8'h00;
	localparam logic [PINS-1:0] FLAG_RST = 8'h00;

	// External interrupt sense modes
	typedef enum logic [1:0] {
		SENSE_LOW = 2'h0,
		SENSE_ANY = 2'h1,
		SENSE_FALL = 2'h2,
		SENSE_RISE = 2'h3
	} gps_sense_e;

	// Bus answer states, one-hot
	typedef enum logic [1:0] {
		BUS_IDLE = 2'h1,
		BUS_ACK = 2'h2
	} gps_bus_e;

	// Override bundle driven by peripherals owning alternate functions
	typedef struct packed {
		logic [PINS-1:0] pullup_override_en;
		logic [PINS-1:0] pullup_override_val;
		logic [PINS-1:0] direction_override_en;
		logic [PINS-1:0] direction_override_val;
		logic [PINS-1:0] portvalue_override_en;
		logic [PINS-1:0] portvalue_override_val;
		logic [PINS-1:0] input_enable_override_en;
		logic [PINS-1:0] input_enable_override_val;
	} gps_ovr_s;

endpackage : gps_pkg

// ---- hw/gps_sync.sv ----
/*
 * Two-stage pin synchroniser: a latch open while the clock is high,
 * then a flip-flop on the next rising edge.
 * Assumes one clock; the input may change at any time.
 */
`timescale 1ns/1ps
`default_nettype none

module gps_sync #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] hold_latch;

	// Transparent while clock high, closes on the falling edge
	always_latch begin
		if (core_clk) begin
			hold_latch <= d;
		end
	end

	// Held value moves into the sample bit at the next rising edge
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= hold_latch;
		end
	end

endmodule : gps_sync

`default_nettype wire

// ---- hw/gps_pin_ctl.sv ----
/*
 * Per-pin override logic: pull-up, driver enable, driven level,
 * digital input enable and sleep clamp, bitwise over all pins.
 * Assumes overrides come straight from the owning peripherals.
 */
`timescale 1ns/1ps
`default_nettype none

module gps_pin_ctl (
	// Software controls
	input wire logic [gps_pkg::PINS-1:0] dir,
	input wire logic [gps_pkg::PINS-1:0] outv,
	input wire logic global_pullup_disable,
	input wire logic [gps_pkg::PINS-1:0] ext_en,
	input wire logic sleep_clamp,
	// Peripheral overrides
	input wire gps_pkg::gps_ovr_s ovr,
	// Pad level
	input wire logic [gps_pkg::PINS-1:0] pad_in,
	// Results
	output logic [gps_pkg::PINS-1:0] drive_en,
	output logic [gps_pkg::PINS-1:0] drive_val,
	output logic [gps_pkg::PINS-1:0] pullup_on,
	output logic [gps_pkg::PINS-1:0] in_clamped
);

	logic [gps_pkg::PINS-1:0] pull_plain;
	logic [gps_pkg::PINS-1:0] in_plain;
	logic [gps_pkg::PINS-1:0] in_en;

	// Pull-up only for input, data one, no global disable
	assign pull_plain = ~dir & outv & {gps_pkg::PINS{~global_pullup_disable}};
	assign pullup_on = (ovr.pullup_override_en & ovr.pullup_override_val)
		| (~ovr.pullup_override_en & pull_plain);

	// Driver enable and driven level
	assign drive_en = (ovr.direction_override_en & ovr.direction_override_val)
		| (~ovr.direction_override_en & dir);
	assign drive_val = (ovr.portvalue_override_en & ovr.portvalue_override_val)
		| (~ovr.portvalue_override_en & outv);

	// Sleep clamps inputs unless the external request keeps them alive
	assign in_plain = ~{gps_pkg::PINS{sleep_clamp}} | ext_en;
	assign in_en = (ovr.input_enable_override_en & ovr.input_enable_override_val)
		| (~ovr.input_enable_override_en & in_plain);
	assign in_clamped = pad_in & in_en;

endmodule : gps_pin_ctl

`default_nettype wire

// ---- hw/gps_port.sv ----
/*
 * General-purpose pin port: Wishbone register file, pin synchroniser,
 * sleep clamp, peripheral overrides and external interrupt edge flags.
 * Assumes one 10 MHz clock, synchronous active-low reset, pads outside.
 */
// How it works
// - Sample bit shows the synchronised pad level in either direction.
// - First stage is a latch open while clock high, shut on fall.
// - Latched value enters the sample bit at the next rising edge.
// - A software write changes the pad at its own edge, one-period readback.
// - Deep sleep clamps digital inputs to zero unless overridden.
// - Enabled external interrupt pins skip the sleep clamp.
// - Clamped high pin sets its flag on wake in rising or any-edge sense.
// - Pull-ups are off while reset is held.
// - Pull-up follows override, else on for dir 0, data 1, no disable.
// - Driver enable follows direction override, else the direction bit.
// - Driven level follows port-value override, else the data bit.
// - Input enable follows its override, else the sleep setting.
// - Alternate digital input is taken after clamp, before synchroniser.
// - Analog path joins the pad directly, both ways.
// - Override signals come from the peripheral owning the function.
// - Direction one drives data bit; zero is input, pull-up if data one.
// - Global pull-up disable kills every pull-up without a pull-up override.
// - Pins float at once when reset is active, clock or not.
`timescale 1ns/1ps
`default_nettype none

module gps_port (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Pads
	input wire logic [gps_pkg::PINS-1:0] pad_in,
	output logic [gps_pkg::PINS-1:0] pad_out,
	output logic [gps_pkg::PINS-1:0] pad_oe_n,
	output logic [gps_pkg::PINS-1:0] pullup_en,
	// Sleep controller
	input wire logic sleep_clamp,
	// Alternate functions
	input wire gps_pkg::gps_ovr_s ovr,
	output logic [gps_pkg::PINS-1:0] alt_digital_input
);

	// Registers
	logic [gps_pkg::PINS-1:0] pin_direction_reg;
	logic [gps_pkg::PINS-1:0] pin_direction_next;
	logic [gps_pkg::PINS-1:0] pin_output_data_reg;
	logic [gps_pkg::PINS-1:0] pin_output_data_next;
	logic [7:0] mcu_control_reg;
	logic [7:0] mcu_control_next;
	logic [gps_pkg::PINS-1:0] int_enable_reg;
	logic [gps_pkg::PINS-1:0] int_enable_next;
	logic [gps_pkg::PINS-1:0] int_flag_reg;
	logic [gps_pkg::PINS-1:0] int_flag_next;
	logic [gps_pkg::PINS-1:0] sample_prev_reg;
	logic [gps_pkg::PINS-1:0] pad_out_reg;
	logic [gps_pkg::PINS-1:0] pad_drive_reg;
	logic [gps_pkg::PINS-1:0] pullup_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic ack_reg;
	gps_pkg::gps_bus_e bus_state_reg;
	gps_pkg::gps_bus_e bus_state_next;

	// Wires
	logic [gps_pkg::PINS-1:0] pin_sample_bit;
	logic [gps_pkg::PINS-1:0] in_clamped;
	logic [gps_pkg::PINS-1:0] drive_en;
	logic [gps_pkg::PINS-1:0] drive_val;
	logic [gps_pkg::PINS-1:0] pullup_on;
	logic [gps_pkg::PINS-1:0] edge_rise;
	logic [gps_pkg::PINS-1:0] edge_fall;
	logic [gps_pkg::PINS-1:0] edge_hit;
	logic [gps_pkg::PINS-1:0] flag_clr;
	logic global_pullup_disable_next;
	gps_pkg::gps_sense_e sense_mode;
	logic bus_req;
	logic wr_fire;
	logic wr_lane0;
	logic hit_dir;
	logic hit_out;
	logic hit_sample;
	logic hit_mcu;
	logic hit_inten;
	logic hit_flag;

	// Bus request and address decode
	assign bus_req = wb_cyc_i & wb_stb_i;
	assign wr_fire = bus_req & wb_we_i & ack_reg;
	assign wr_lane0 = wr_fire & wb_sel_i[0];
	assign hit_dir = (wb_adr_i == gps_pkg::OFS_DIR);
	assign hit_out = (wb_adr_i == gps_pkg::OFS_OUT);
	assign hit_sample = (wb_adr_i == gps_pkg::OFS_SAMPLE);
	assign hit_mcu = (wb_adr_i == gps_pkg::OFS_MCU);
	assign hit_inten = (wb_adr_i == gps_pkg::OFS_INTEN);
	assign hit_flag = (wb_adr_i == gps_pkg::OFS_FLAG);

	// Bus answer: one wait state, ack one cycle, then dropped
	assign bus_state_next = (bus_state_reg == gps_pkg::BUS_IDLE && bus_req) ? gps_pkg::BUS_ACK
		: gps_pkg::BUS_IDLE;

	// Read mux; unmapped addresses answer with zero
	assign rdata_next = hit_dir ? {24'h000000, pin_direction_reg}
		: hit_out ? {24'h000000, pin_output_data_reg}
		: hit_sample ? {24'h000000, pin_sample_bit}
		: hit_mcu ? {24'h000000, mcu_control_reg}
		: hit_inten ? {24'h000000, int_enable_reg}
		: hit_flag ? {24'h000000, int_flag_reg}
		: 32'h00000000;

	// Register write values, taken at the acknowledging edge only
	assign pin_direction_next = (wr_lane0 && hit_dir) ? wb_dat_i[gps_pkg::PINS-1:0]
		: pin_direction_reg;
	assign pin_output_data_next = (wr_lane0 && hit_out) ? wb_dat_i[gps_pkg::PINS-1:0]
		: pin_output_data_reg;
	assign mcu_control_next = (wr_lane0 && hit_mcu) ? (wb_dat_i[7:0] & gps_pkg::MCU_WR_MASK)
		: mcu_control_reg;
	assign int_enable_next = (wr_lane0 && hit_inten) ? wb_dat_i[gps_pkg::PINS-1:0]
		: int_enable_reg;
	assign global_pullup_disable_next = mcu_control_next[gps_pkg::MCU_PUD_BIT];
	assign sense_mode = gps_pkg::gps_sense_e'(mcu_control_reg[gps_pkg::MCU_SENSE_LO +: 2]);

	// Pin control from next-state bits so a write reaches the pad at its own edge
	gps_pin_ctl u_pin_ctl (
		.dir(pin_direction_next),
		.outv(pin_output_data_next),
		.global_pullup_disable(global_pullup_disable_next),
		.ext_en(int_enable_reg),
		.sleep_clamp(sleep_clamp),
		.ovr(ovr),
		.pad_in(pad_in),
		.drive_en(drive_en),
		.drive_val(drive_val),
		.pullup_on(pullup_on),
		.in_clamped(in_clamped)
	);

	// Synchroniser sees the clamped level, so sleep shows as zero
	gps_sync #(
		.W(gps_pkg::PINS)
	) u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.d(in_clamped),
		.q(pin_sample_bit)
	);

	// Edge detection on the synchronised level for interrupt flags
	assign edge_rise = pin_sample_bit & ~sample_prev_reg;
	assign edge_fall = ~pin_sample_bit & sample_prev_reg;
	assign edge_hit = (sense_mode == gps_pkg::SENSE_RISE) ? edge_rise
		: (sense_mode == gps_pkg::SENSE_FALL) ? edge_fall
		: (sense_mode == gps_pkg::SENSE_ANY) ? (edge_rise | edge_fall)
		: '0;
	// Flags latch even with the request disabled; a new edge beats a clear
	assign flag_clr = (wr_lane0 && hit_flag) ? wb_dat_i[gps_pkg::PINS-1:0] : '0;
	assign int_flag_next = (int_flag_reg & ~flag_clr) | edge_hit;

	// Alternate input: after the clamp, before the synchroniser
	assign alt_digital_input = in_clamped;
	// Analog path is the pad net itself in the pad ring; no logic here

	// Reset forces float and pull-up off without waiting for a clock edge
	assign pad_oe_n = ~pad_drive_reg | {gps_pkg::PINS{~rst_n}};
	assign pullup_en = pullup_reg & {gps_pkg::PINS{rst_n}};
	assign pad_out = pad_out_reg;
	assign wb_dat_o = rdata_reg;
	assign wb_ack_o = ack_reg;

	// Bus state and answer
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			bus_state_reg <= gps_pkg::BUS_IDLE;
			ack_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			bus_state_reg <= bus_state_next;
			ack_reg <= (bus_state_next == gps_pkg::BUS_ACK);
			rdata_reg <= rdata_next;
		end
	end

	// Software registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pin_direction_reg <= gps_pkg::DIR_RST;
			pin_output_data_reg <= gps_pkg::OUT_RST;
			mcu_control_reg <= gps_pkg::MCU_RST;
			int_enable_reg <= gps_pkg::INTEN_RST;
		end else begin
			pin_direction_reg <= pin_direction_next;
			pin_output_data_reg <= pin_output_data_next;
			mcu_control_reg <= mcu_control_next;
			int_enable_reg <= int_enable_next;
		end
	end

	// Flags and edge history
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			int_flag_reg <= gps_pkg::FLAG_RST;
			sample_prev_reg <= '0;
		end else begin
			int_flag_reg <= int_flag_next;
			sample_prev_reg <= pin_sample_bit;
		end
	end

	// Pad drivers, updated at the write edge itself
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pad_out_reg <= '0;
			pad_drive_reg <= '0;
			pullup_reg <= '0;
		end else begin
			pad_out_reg <= drive_val;
			pad_drive_reg <= drive_en;
			pullup_reg <= pullup_on;
		end
	end

	// Bus request waiting for its answer
	sequence bus_wait_s;
		bus_req && !ack_reg && bus_state_reg == gps_pkg::BUS_IDLE;
	endsequence

	// Answer given, then taken away
	sequence bus_answer_s;
		ack_reg ##1 !ack_reg;
	endsequence

	ack_timing_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		bus_wait_s |=> bus_answer_s)
		else $error("bus ack not one cycle after request");

	dir_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(wr_lane0 && hit_dir) |=> pin_direction_reg == $past(wb_dat_i[7:0])
			&& pad_oe_n == ~($past(ovr.direction_override_en) & $past(ovr.direction_override_val)
			| ~$past(ovr.direction_override_en) & $past(wb_dat_i[7:0])))
		else $error("direction write not seen on pad enable");

	out_level_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		1'b1 |=> pad_out == (($past(ovr.portvalue_override_en) & $past(ovr.portvalue_override_val))
			| (~$past(ovr.portvalue_override_en) & $past(pin_output_data_next))))
		else $error("driven level wrong");

	pullup_rule_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(global_pullup_disable_next && ovr.pullup_override_en == '0) |=> pullup_en == '0)
		else $error("pull-up on despite global disable");

	pullup_reset_a: assert property (@(posedge core_clk)
		!rst_n |-> pullup_en == '0 && pad_oe_n == '1)
		else $error("pull-up or driver active in reset");

	reset_dir_a: assert property (@(posedge core_clk)
		!rst_n |=> pin_direction_reg == '0 && pin_output_data_reg == '0)
		else $error("direction or data not cleared by reset");

	sleep_clamp_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sleep_clamp && int_enable_reg == '0 && ovr.input_enable_override_en == '0)
			|-> alt_digital_input == '0)
		else $error("input not clamped in sleep");

	wake_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(sense_mode == gps_pkg::SENSE_RISE && edge_rise != '0 && !wr_lane0)
			|=> (int_flag_reg & $past(edge_rise)) == $past(edge_rise))
		else $error("edge flag not set");

	sample_path_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(in_clamped == '1) [*3] |=> pin_sample_bit == '1)
		else $error("sample bit not following steady pad");

	// Steady low level must also come through, not only highs
	sample_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(in_clamped == '0) [*3] |=> pin_sample_bit == '0)
		else $error("sample bit not following steady low pad");

	// Awake and without override the alternate input is the bare pad
	alt_awake_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!sleep_clamp && ovr.input_enable_override_en == '0) |-> alt_digital_input == pad_in)
		else $error("alternate input differs from awake pad");

	// Override wins both ways, whatever the sleep state
	ie_override_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		((alt_digital_input ^ pad_in) & ovr.input_enable_override_en & ovr.input_enable_override_val) == '0
			&& (alt_digital_input & ovr.input_enable_override_en & ~ovr.input_enable_override_val) == '0)
		else $error("input-enable override ignored");

	// Request pins keep their input alive through the clamp, for wake-up
	int_bypass_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		sleep_clamp |-> ((alt_digital_input ^ pad_in) & int_enable_reg & ~ovr.input_enable_override_en) == '0)
		else $error("clamp not bypassed for request pin");

	// Without override the driver follows the direction bit as written
	drive_plain_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ovr.direction_override_en == '0) |=> pad_oe_n == ~$past(pin_direction_next))
		else $error("driver not following direction bit");

	// Without override or disable: pull-up only for an input with data one
	pull_plain_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ovr.pullup_override_en == '0 && !global_pullup_disable_next)
			|=> pullup_en == (~$past(pin_direction_next) & $past(pin_output_data_next)))
		else $error("pull-up not input with data one");

	// An edge in the cycle of a clear must not be lost
	flag_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(edge_hit != '0) |=> (int_flag_reg & $past(edge_hit)) == $past(edge_hit))
		else $error("edge lost against a clear");

	// A clear with no new edge empties the written bits
	flag_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(wr_lane0 && hit_flag && edge_hit == '0) |=> (int_flag_reg & $past(wb_dat_i[7:0])) == '0)
		else $error("flag clear ignored");

	// Ack is a one-cycle pulse even if the master holds its request
	ack_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		ack_reg |=> !ack_reg)
		else $error("ack held over two cycles");

	// Read data must stand in the cycle the master samples ack
	read_dir_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ack_reg && bus_req && !wb_we_i && hit_dir) |-> wb_dat_o == {24'h000000, pin_direction_reg})
		else $error("direction read data wrong at ack");

	// Writes without byte lane zero are acked but dropped
	lane_drop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(bus_req && wb_we_i && ack_reg && !wb_sel_i[0])
			|=> pin_direction_reg == $past(pin_direction_reg) && mcu_control_reg == $past(mcu_control_reg))
		else $error("write without lane zero landed");

	// Reserved control bits read zero, so software sees no stale junk
	mcu_mask_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(mcu_control_reg & ~gps_pkg::MCU_WR_MASK) == 8'h00)
		else $error("reserved control bit set");

endmodule : gps_port

`default_nettype wire

// ---- sim/gps_pad_model.sv ----
/*
 * Pad environment of the pin port: each pad carries the port's own
 * driven level, else its pull-up, else the level applied from outside.
 * Assumes the bench always applies a defined outside level.
 */
`timescale 1ns/1ps
`default_nettype none

module gps_pad_model (
	// From the port
	input wire logic [gps_pkg::PINS-1:0] pad_out,
	input wire logic [gps_pkg::PINS-1:0] pad_oe_n,
	input wire logic [gps_pkg::PINS-1:0] pullup_en,
	// Outside world
	input wire logic [gps_pkg::PINS-1:0] ext_level,
	output logic [gps_pkg::PINS-1:0] pad_in
);
	// Own driver wins, a pull-up beats the weak outside level
	assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & pullup_en) | (pad_oe_n & ~pullup_en & ext_level);
endmodule : gps_pad_model

`default_nettype wire

// ---- sim/gps_port_bench.sv ----
/*
 * Self-checking bench of the pin port: table of pad settings, sleep clamp,
 * wake flags, reset behaviour and register reads.
 * Assumes the pad model closes the loop from the pads back to pad_in.
 */
`timescale 1ns/1ps
`default_nettype none

module gps_port_bench;
	typedef struct packed {
		logic [7:0] dir, outv, ctl, pu_e, pu_v, dd_e, dd_v, pv_e, pv_v, oe_n, drv, pu, smp;
	} gps_row_s;

	logic core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sleep_clamp;
	logic [7:0] wb_adr_i, ext_level, pad_in, pad_out, pad_oe_n, pullup_en, alt_digital_input;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	gps_pkg::gps_ovr_s ovr;
	int n_mismatch = 0;
	int comparisons = 0;

	// Settings and the pads they should give; low pins float to 0 outside
	gps_row_s rows [5] = '{
		{8'hf0, 8'hcc, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0f, 8'hc0, 8'h0c, 8'hcc},
		{8'hf0, 8'hcc, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0f, 8'hc0, 8'h00, 8'hc0},
		{8'h00, 8'hff, 8'h00, 8'h0f, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'hf5, 8'hf5},
		{8'h0f, 8'h55, 8'h00, 8'h00, 8'h00, 8'hff, 8'hf0, 8'h00, 8'h00, 8'h0f, 8'h50, 8'h50, 8'h50},
		{8'hff, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3c, 8'hf0, 8'h00, 8'h33, 8'h00, 8'h33}
	};

	gps_port i_gps_port (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe_n(pad_oe_n), .pullup_en(pullup_en), .sleep_clamp(sleep_clamp), .ovr(ovr),
		.alt_digital_input(alt_digital_input));

	gps_pad_model i_gps_pad_model (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .pullup_en(pullup_en),
		.ext_level(ext_level), .pad_in(pad_in));

	// Free-running 10 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up

	// One classic cycle; request held until ack is sampled, no latency assumed
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] dat);
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= {24'h000000, dat};
		do @(posedge core_clk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb_xfer

	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask : idle

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		idle(20000);
		n_mismatch++;
		wrap_up();
	end

	initial begin
		rst_n <= 1'b0;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		wb_adr_i <= 8'h00;
		wb_sel_i <= 4'hf;
		wb_dat_i <= 32'h00000000;
		ext_level <= 8'h00;
		sleep_clamp <= 1'b0;
		ovr <= '0;
		idle(1);
		#1 chk("oe_n in reset", 32'(pad_oe_n), 32'h000000ff);
		idle(1);
		rst_n <= 1'b1;
		// Every register and an unmapped place read zero after reset
		for (int a = 0; a <= 24; a += 4) begin
			wb_xfer(1'b0, 8'(a), 8'h00);
			chk("reset read", rd, 32'h00000000);
		end
		$display("test reset done");

		// Table: low input pins 2 and 3, with data one, get pull-ups in row one
		foreach (rows[i]) begin
			ovr <= {rows[i].pu_e, rows[i].pu_v, rows[i].dd_e, rows[i].dd_v, rows[i].pv_e, rows[i].pv_v, 16'h0000};
			wb_xfer(1'b1, gps_pkg::OFS_MCU, rows[i].ctl);
			wb_xfer(1'b1, gps_pkg::OFS_DIR, rows[i].dir);
			wb_xfer(1'b1, gps_pkg::OFS_OUT, rows[i].outv);
			#1 chk("oe_n", 32'(pad_oe_n), 32'(rows[i].oe_n));
			chk("pad_out", 32'(pad_out & ~rows[i].oe_n), 32'(rows[i].drv));
			chk("pullup", 32'(pullup_en), 32'(rows[i].pu));
			idle(1); // one spare cycle before reading back
			wb_xfer(1'b0, gps_pkg::OFS_SAMPLE, 8'h00);
			chk("sample", rd, 32'(rows[i].smp));
		end
		$display("test table done");

		// Sleep clamp with interrupt-enable bypass and input-enable overrides
		wb_xfer(1'b1, gps_pkg::OFS_MCU, 8'h00);
		wb_xfer(1'b1, gps_pkg::OFS_DIR, 8'h00);
		wb_xfer(1'b1, gps_pkg::OFS_OUT, 8'h00);
		wb_xfer(1'b1, gps_pkg::OFS_INTEN, 8'h03);
		ovr <= {48'h000000000000, 8'hf0, 8'h30};
		ext_level <= 8'hff;
		idle(4);
		#1 chk("alt awake", 32'(alt_digital_input), 32'h0000003f);
		@(posedge core_clk);
		sleep_clamp <= 1'b1;
		idle(4);
		#1 chk("alt asleep", 32'(alt_digital_input), 32'h00000033);
		wb_xfer(1'b0, gps_pkg::OFS_SAMPLE, 8'h00);
		chk("sample asleep", rd, 32'h00000033);
		$display("test sleep done");

		// Wake from clamp on high pins, every sense mode, interrupts off
		sleep_clamp <= 1'b0;
		ovr <= '0;
		wb_xfer(1'b1, gps_pkg::OFS_INTEN, 8'h00);
		for (int m = 0; m < 4; m++) begin
			wb_xfer(1'b1, gps_pkg::OFS_MCU, 8'(m));
			sleep_clamp <= 1'b1;
			idle(4);
			wb_xfer(1'b1, gps_pkg::OFS_FLAG, 8'hff);
			sleep_clamp <= 1'b0;
			idle(4);
			wb_xfer(1'b0, gps_pkg::OFS_FLAG, 8'h00);
			chk("wake flags", rd, (m == 1 || m == 3) ? 32'h000000ff : 32'h00000000);
			wb_xfer(1'b1, gps_pkg::OFS_FLAG, 8'hff);
		end
		// Rising wake edge timed to land on the clearing write's ack edge
		sleep_clamp <= 1'b1;
		idle(4);
		fork
			wb_xfer(1'b1, gps_pkg::OFS_FLAG, 8'hff);
			begin
				@(posedge core_clk);
				sleep_clamp <= 1'b0;
			end
		join
		wb_xfer(1'b0, gps_pkg::OFS_FLAG, 8'h00);
		chk("set beats clear", rd, 32'h000000ff);
		$display("test wake done");

		// Reset in mid-run floats pads and drops pull-ups before any edge
		ext_level <= 8'h00;
		wb_xfer(1'b1, gps_pkg::OFS_DIR, 8'h0f);
		wb_xfer(1'b1, gps_pkg::OFS_OUT, 8'hf0);
		idle(1);
		rst_n <= 1'b0;
		#1 chk("oe_n at reset", 32'(pad_oe_n), 32'h000000ff);
		chk("pullup at reset", 32'(pullup_en), 32'h00000000);
		idle(2);
		rst_n <= 1'b1;
		wb_xfer(1'b0, gps_pkg::OFS_DIR, 8'h00);
		chk("dir after reset", rd, 32'h00000000);
		wb_xfer(1'b0, gps_pkg::OFS_OUT, 8'h00);
		chk("out after reset", rd, 32'h00000000);
		// A write without byte lane zero is acked but must not land
		wb_sel_i <= 4'he;
		wb_xfer(1'b1, gps_pkg::OFS_DIR, 8'hff);
		wb_sel_i <= 4'hf;
		wb_xfer(1'b0, gps_pkg::OFS_DIR, 8'h00);
		chk("lane zero off", rd, 32'h00000000);
		// Writes to the read-only sample and an unmapped place change nothing
		wb_xfer(1'b1, gps_pkg::OFS_SAMPLE, 8'hff);
		wb_xfer(1'b1, 8'h18, 8'hff);
		wb_xfer(1'b0, 8'h18, 8'h00);
		chk("unmapped", rd, 32'h00000000);
		wb_xfer(1'b0, gps_pkg::OFS_SAMPLE, 8'h00);
		chk("sample ro", rd, 32'h00000000);
		$display("test mid reset done");
		wrap_up();
	end
endmodule : gps_port_bench

`default_nettype wire
